/* rtl/srcs_pkg.sv */
// Purpose: Shared constants for the reset and clock sequencer.
// Assumes: One reference clock at 250 MHz drives all logic.
// Notes: Register offsets are byte addresses on the strobed register port.
package srcs_pkg;
   localparam logic [15:0] BREAK_STATE_FLAGS_OFF = 16'hFE00;
   localparam logic [15:0] RESET_CAUSE_FLAGS_OFF = 16'hFE01;
   localparam logic [15:0] WAKE_CTRL_OFF = 16'hFE02;
   localparam logic [15:0] BREAK_FLAG_CLEAR_CONTROL_OFF = 16'hFE03;
   localparam logic [15:0] VECTOR_USER = 16'hFFFE;
   localparam logic [15:0] VECTOR_MONITOR = 16'hFEFE;
   localparam int CAUSE_POR_BIT = 7;
   localparam int CAUSE_PIN_BIT = 6;
   localparam int CAUSE_WDOG_BIT = 5;
   localparam int CAUSE_OPC_BIT = 4;
   localparam int CAUSE_ADR_BIT = 3;
   localparam int CAUSE_LVI_BIT = 1;
   localparam int BW_BIT = 1;
   localparam int BREAK_CLEAR_ENABLE_BIT = 7;
   localparam int CNT_W = 13;
   localparam int POR_CYCLES = 4096;
   localparam int SHORT_STOP_CYCLES = 32;
   localparam int DRIVE_CYCLES = 32;
   localparam int HOLD_CYCLES = 32;
   localparam int PIN_MIN_CYCLES = 67;
   localparam int POR_PIN_CYCLES = 4163;
   localparam logic [7:0] CAUSE_RESET = 8'h80;
   localparam logic [7:0] ZERO8 = 8'h00;
   typedef enum logic [2:0] {
      SRCS_POR_WAIT, SRCS_DRIVE, SRCS_HOLD, SRCS_RUN, SRCS_STOP, SRCS_PIN_LOW
   } srcs_state_t;
endpackage

/* rtl/srcs_sequencer.sv */
// What this block does
// - All CPU and peripheral clocks come from the one core source clock.
// - Bus clock is the core source clock divided by two.
// - Bus rate is the reference or PLL clock divided by four.
// - After power-on or brown-out, hold clocks off and pin low for 4096 cycles.
// - Stop exit keeps clocks off for a selectable 4096 or 32 cycle delay.
// - Wait mode stops CPU clocks while two peripheral clock sets run.
// - Every reset source asserts internal reset and selects the reset vector; in stop, watchdog, bad opcode and bad address requests do not assert it.
// - Internal reset returns the wake, break and interrupt registers to defaults; cause flags are kept.
// - Internal resets clear the timing counter; pin resets do not.
// - Each reset source sets its own cause bit.
// - Pin low halts all; pin cause bit needs 67 low cycles.
// - After power-on or brown-out the pin cause bit needs 4163 cycles.
// - Internal resets drive the pin 32 cycles, then hold reset 32 more.
// - Power-on or brown-out drives pin 4096 cycles before the normal sequence.
// - Watchdog request is taken asynchronously to the bus clock.
// - Up to 24 interrupt sources are accepted.
// - Cause register layout: 7 por, 6 pin, 5 wdog, 4 opc, 3 adr, 1 lvi.
// - Break status holds break-during-wait flag at bit 1.
// - Break flag control holds break-clear enable at bit 7.
// - Power-on sets the power-on bit and clears all other cause bits.
// - Timing counter is 13 bits and steps with the reference clock.
// - Short wakeup select 1 uses 32 cycles, 0 uses 4096.
//
// Purpose: Reset sequencing, clock gating and reset cause recording.
// Assumes: sys_clk_i is the reference clock; the core source clock is
//    presented as a one-cycle enable, so all gated clocks are enables.
// Notes: reset_i is the power-on detect pulse; it restarts everything.
////////////////////////////////////////////////////////////////////////////////
//
// Chosen here: the strobed register port.
module srcs_sequencer #(
   parameter int POR_TIMEOUT = srcs_pkg::POR_CYCLES,
   parameter int IRQ_COUNT = 24
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic core_src_en_i,
   input wire logic monitor_mode_i,
   input wire logic brownout_i,
   input wire logic watchdog_req_i,
   input wire logic bad_opcode_i,
   input wire logic bad_fetch_address_i,
   input wire logic stop_req_i,
   input wire logic wait_req_i,
   input wire logic wake_i,
   input wire logic break_wait_i,
   input wire logic [IRQ_COUNT-1:0] irq_i,
   input wire logic reset_pin_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [7:0] reg_rdata_o,
   output logic reset_pin_o,
   output logic reset_pin_oe_n_o,
   output logic internal_reset_o,
   output logic [15:0] reset_vector_o,
   output logic cpu_clk_en_o,
   output logic periph_clk_en_o,
   output logic wait_clk_en_o,
   output logic [IRQ_COUNT-1:0] irq_pending_o,
   output logic [srcs_pkg::CNT_W-1:0] timing_count_o
);

   ////////////////////////////////////////////////////////////////////////////
   localparam logic [12:0] POR_LAST = 13'(POR_TIMEOUT - 1);
   localparam logic [12:0] SHORT_LAST = 13'(srcs_pkg::SHORT_STOP_CYCLES - 1);
   localparam logic [12:0] DRIVE_LAST = 13'(srcs_pkg::DRIVE_CYCLES - 1);
   localparam logic [12:0] HOLD_LAST = 13'(srcs_pkg::HOLD_CYCLES - 1);
   localparam logic [12:0] PIN_LAST = 13'(srcs_pkg::PIN_MIN_CYCLES - 1);
   localparam logic [12:0] POR_PIN_LAST = 13'(srcs_pkg::POR_PIN_CYCLES - 1);

   srcs_pkg::srcs_state_t state_q;
   logic [12:0] cnt_q;
   logic [12:0] phase_q;
   logic [12:0] pin_cnt_q;
   logic pin_meta_q, pin_low_q;
   logic wd_meta_q, wd_sync_q;
   logic from_por_q;
   logic pin_seen_q;
   logic bus_div_q;
   logic bus_en_q;
   logic short_wake_q;
   logic break_clear_enable_q;
   logic bw_q;
   logic [7:0] cause_q;
   logic int_src;
   logic lvi_hit;
   logic wake_seen_q;

   function automatic logic reached(input logic [12:0] c, input logic [12:0] last);
      reached = (c >= last);
   endfunction

   // The pin is driven only in the power-on wait and the drive phase.
   function automatic logic drives_pin(input srcs_pkg::srcs_state_t s);
      drives_pin = (s == srcs_pkg::SRCS_POR_WAIT || s == srcs_pkg::SRCS_DRIVE);
   endfunction

   // Every state but run and stop keeps the chip in reset.
   function automatic logic holds_reset(input srcs_pkg::srcs_state_t s);
      holds_reset = (s != srcs_pkg::SRCS_RUN && s != srcs_pkg::SRCS_STOP);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // A wake event may be a one-cycle pulse, so it is held here until the
   // stop delay runs out; otherwise the delay would restart at once.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || state_q != srcs_pkg::SRCS_STOP) begin
         wake_seen_q <= 1'b0;
      end else if (wake_i) begin
         wake_seen_q <= 1'b1;
      end
   end

   // Pin and watchdog arrive from outside this clock, so both get two flops.
   // A watchdog request shorter than one cycle can be missed.
   // Callers must hold it for at least that long.
   always_ff @(posedge sys_clk_i) begin
      pin_meta_q <= ~reset_pin_i;
      pin_low_q <= pin_meta_q;
      wd_meta_q <= watchdog_req_i;
      wd_sync_q <= wd_meta_q;
   end

   assign lvi_hit = brownout_i;
   assign int_src = wd_sync_q | bad_opcode_i | bad_fetch_address_i | lvi_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer. The counter is shared; only internal sources and stop entry clear it.
   // A pin episode leaves the counter alone, so it keeps its phase.
   // Brown-out is checked before the case so that it restarts the
   // long wait from any state but the wait itself.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_q <= srcs_pkg::SRCS_POR_WAIT;
         cnt_q <= '0;
         phase_q <= '0;
         from_por_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 13'd1;
         phase_q <= phase_q + 13'd1;
         if (lvi_hit && state_q != srcs_pkg::SRCS_POR_WAIT) begin
            state_q <= srcs_pkg::SRCS_POR_WAIT;
            cnt_q <= '0;
            phase_q <= '0;
            from_por_q <= 1'b1;
         end else begin
            case (state_q)
               srcs_pkg::SRCS_POR_WAIT: begin
                  if (reached(phase_q, POR_LAST)) begin
                     state_q <= srcs_pkg::SRCS_DRIVE;
                     phase_q <= '0;
                  end
               end
               srcs_pkg::SRCS_DRIVE: begin
                  if (reached(phase_q, DRIVE_LAST)) begin
                     state_q <= srcs_pkg::SRCS_HOLD;
                     phase_q <= '0;
                  end
               end
               srcs_pkg::SRCS_HOLD: begin
                  if (reached(phase_q, HOLD_LAST)) begin
                     state_q <= srcs_pkg::SRCS_RUN;
                     from_por_q <= 1'b0;
                  end
               end
               srcs_pkg::SRCS_RUN: begin
                  if (int_src) begin
                     state_q <= srcs_pkg::SRCS_DRIVE;
                     cnt_q <= '0;
                     phase_q <= '0;
                  end else if (pin_low_q) begin
                     state_q <= srcs_pkg::SRCS_PIN_LOW;
                     phase_q <= '0;
                  end else if (stop_req_i) begin
                     state_q <= srcs_pkg::SRCS_STOP;
                     cnt_q <= '0;
                     phase_q <= '0;
                  end
               end
               srcs_pkg::SRCS_STOP: begin
                  // Wake delay counts only once a wake event or a low pin is seen.
                  if (!(wake_i || wake_seen_q || pin_low_q)) begin
                     phase_q <= '0;
                  end else if (reached(phase_q, short_wake_q ? SHORT_LAST : POR_LAST)) begin
                     state_q <= pin_low_q ? srcs_pkg::SRCS_PIN_LOW : srcs_pkg::SRCS_RUN;
                     phase_q <= '0;
                  end
               end
               srcs_pkg::SRCS_PIN_LOW: begin
                  if (int_src) begin
                     state_q <= srcs_pkg::SRCS_DRIVE;
                     cnt_q <= '0;
                     phase_q <= '0;
                  end else if (!pin_low_q) begin
                     state_q <= srcs_pkg::SRCS_HOLD;
                     phase_q <= '0;
                  end
               end
               default: state_q <= srcs_pkg::SRCS_POR_WAIT;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Length of a pin-low episode, measured on the synchronised level.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pin_cnt_q <= '0;
         pin_seen_q <= 1'b0;
      end else if (!pin_low_q) begin
         pin_cnt_q <= '0;
         pin_seen_q <= 1'b0;
      end else begin
         if (!reached(pin_cnt_q, POR_PIN_LAST)) begin
            pin_cnt_q <= pin_cnt_q + 13'd1;
         end
         pin_seen_q <= reached(pin_cnt_q, from_por_q ? POR_PIN_LAST : PIN_LAST);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cause flags: each source sets its bit; power-on clears the rest.
   // A new reset rewrites the whole register, except a pin reset after power-on, which only adds the pin bit.
   // After a power-on the pin bit waits for the long count.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cause_q <= srcs_pkg::CAUSE_RESET;
      end else if (state_q == srcs_pkg::SRCS_RUN || state_q == srcs_pkg::SRCS_STOP
                   || state_q == srcs_pkg::SRCS_PIN_LOW) begin
         if (int_src || (pin_seen_q && !from_por_q)) begin
            cause_q <= srcs_pkg::ZERO8;
            cause_q[srcs_pkg::CAUSE_WDOG_BIT] <= wd_sync_q;
            cause_q[srcs_pkg::CAUSE_OPC_BIT] <= bad_opcode_i;
            cause_q[srcs_pkg::CAUSE_ADR_BIT] <= bad_fetch_address_i;
            cause_q[srcs_pkg::CAUSE_LVI_BIT] <= lvi_hit;
            cause_q[srcs_pkg::CAUSE_PIN_BIT] <= pin_seen_q;
         end
      end else if (lvi_hit && state_q != srcs_pkg::SRCS_POR_WAIT) begin
         cause_q <= srcs_pkg::ZERO8;
         cause_q[srcs_pkg::CAUSE_LVI_BIT] <= 1'b1;
      end else if (pin_seen_q && from_por_q) begin
         cause_q[srcs_pkg::CAUSE_PIN_BIT] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers. Internal reset restores defaults.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || internal_reset_o) begin
         short_wake_q <= 1'b0;
         break_clear_enable_q <= 1'b0;
      end else if (reg_write_i) begin
         if (reg_addr_i == srcs_pkg::WAKE_CTRL_OFF) begin
            short_wake_q <= reg_wdata_i[0];
         end else if (reg_addr_i == srcs_pkg::BREAK_FLAG_CLEAR_CONTROL_OFF) begin
            break_clear_enable_q <= reg_wdata_i[srcs_pkg::BREAK_CLEAR_ENABLE_BIT];
         end
      end
   end

   // Break-during-wait flag; a new event wins over the software clear.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || internal_reset_o) begin
         bw_q <= 1'b0;
      end else if (break_wait_i) begin
         bw_q <= 1'b1;
      end else if (reg_write_i && break_clear_enable_q && reg_addr_i == srcs_pkg::BREAK_STATE_FLAGS_OFF
                   && !reg_wdata_i[srcs_pkg::BW_BIT]) begin
         bw_q <= 1'b0;
      end
   end

   // Reads have no side effect on any flag.
   // Unmapped addresses read as zero; data stand for one cycle only.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         reg_rdata_o <= srcs_pkg::ZERO8;
      end else if (reg_read_i) begin
         if (reg_addr_i == srcs_pkg::RESET_CAUSE_FLAGS_OFF) begin
            reg_rdata_o <= cause_q;
         end else if (reg_addr_i == srcs_pkg::BREAK_STATE_FLAGS_OFF) begin
            reg_rdata_o <= {6'h00, bw_q, 1'b0};
         end else if (reg_addr_i == srcs_pkg::BREAK_FLAG_CLEAR_CONTROL_OFF) begin
            reg_rdata_o <= {break_clear_enable_q, 7'h00};
         end else if (reg_addr_i == srcs_pkg::WAKE_CTRL_OFF) begin
            reg_rdata_o <= {7'h00, short_wake_q};
         end else begin
            reg_rdata_o <= srcs_pkg::ZERO8;
         end
      end else begin
         reg_rdata_o <= srcs_pkg::ZERO8;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive, internal reset and reset vector.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         reset_pin_o <= 1'b0;
         reset_pin_oe_n_o <= 1'b0;
         internal_reset_o <= 1'b1;
      end else begin
         reset_pin_o <= 1'b0;
         reset_pin_oe_n_o <= !drives_pin(state_q);
         internal_reset_o <= holds_reset(state_q);
      end
   end

   // The vector follows the monitor strap every cycle, so a strap change
   // between two resets is taken by the next one.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         reset_vector_o <= srcs_pkg::VECTOR_USER;
      end else begin
         reset_vector_o <= monitor_mode_i ? srcs_pkg::VECTOR_MONITOR : srcs_pkg::VECTOR_USER;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus clock: the core source enable halved gives the bus enable, so the
   // bus runs at a quarter of an oscillator or PLL clock at four times bus rate.
   // The core source enable must be a one-cycle pulse; a level would make
   // the divider toggle on every reference cycle.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         bus_div_q <= 1'b0;
         bus_en_q <= 1'b0;
      end else begin
         bus_en_q <= 1'b0;
         if (core_src_en_i) begin
            bus_div_q <= ~bus_div_q;
            bus_en_q <= bus_div_q;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cpu_clk_en_o <= 1'b0;
         periph_clk_en_o <= 1'b0;
         wait_clk_en_o <= 1'b0;
      end else begin
         // Clocks run only in the run state; resets and stop keep them off.
         // Wait mode adds the wait set beside the peripheral set.
         cpu_clk_en_o <= bus_en_q && state_q == srcs_pkg::SRCS_RUN && !wait_req_i;
         periph_clk_en_o <= bus_en_q && state_q == srcs_pkg::SRCS_RUN;
         wait_clk_en_o <= bus_en_q && state_q == srcs_pkg::SRCS_RUN && wait_req_i;
      end
   end

   // Interrupt requests are registered each cycle, not held; the CPU side arbitrates.
   // Masking is left to the CPU as well.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || internal_reset_o) begin
         irq_pending_o <= '0;
      end else begin
         irq_pending_o <= irq_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         timing_count_o <= '0;
      end else begin
         // The copy lags the counter by one cycle, which a prescaler ignores.
         timing_count_o <= cnt_q;
      end
   end

endmodule

/* tb/srcs_pin_model.sv */
// Purpose: External reset line with its pull-up and one peer that may pull it low.
// Assumes: Open-drain wire; the device only ever pulls it low.
// Notes: A released line rests high through the pull-up, never at the last value.
////////////////////////////////////////////////////////////////////////////////
module srcs_pin_model (
   input wire logic reset_pin_o,
   input wire logic reset_pin_oe_n_o,
   input wire logic peer_low_i,
   output logic reset_pin_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // Wired-AND of the device and the peer; the peer holds low for its whole pulse.
   always_comb begin
      reset_pin_i = !peer_low_i && (reset_pin_oe_n_o || reset_pin_o);
   end
endmodule

/* tb/srcs_sequencer_props.sv */
// Purpose: Port-level checks on the reset and clock sequencer.
// Assumes: One clock domain; reset_i is synchronous.
// Notes: Pin drive lengths allow two cycles of registered lag.
////////////////////////////////////////////////////////////////////////////////
module srcs_sequencer_props #(
   parameter int POR_TIMEOUT = 4096
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic monitor_mode_i,
   input wire logic watchdog_req_i,
   input wire logic bad_opcode_i,
   input wire logic reset_pin_i,
   input wire logic reg_read_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reset_pin_o,
   input wire logic reset_pin_oe_n_o,
   input wire logic internal_reset_o,
   input wire logic [15:0] reset_vector_o,
   input wire logic cpu_clk_en_o,
   input wire logic periph_clk_en_o,
   input wire logic [srcs_pkg::CNT_W-1:0] timing_count_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   logic [15:0] low_run_q;
   always_ff @(posedge sys_clk_i) begin
      if (reset_i || reset_pin_oe_n_o) begin
         low_run_q <= 16'h0000;
      end else begin
         low_run_q <= low_run_q + 16'h0001;
      end
   end
   pin_only_low_a: assert property (!reset_pin_o) else $error("pin driven high");
   drive_len_a: assert property ($rose(reset_pin_oe_n_o) |->
      (low_run_q >= 16'h001F && low_run_q <= 16'h0022) ||
      (int'(low_run_q) >= POR_TIMEOUT + 31 && int'(low_run_q) <= POR_TIMEOUT + 34))
      else $error("pin drive length wrong");
   hold_tail_a: assert property ($rose(reset_pin_oe_n_o) |->
      internal_reset_o [*8] ##[23:27] !internal_reset_o) else $error("reset tail wrong");
   clk_gate_a: assert property (internal_reset_o |-> !cpu_clk_en_o && !periph_clk_en_o)
      else $error("clock enable during reset");
   vec_sel_a: assert property ($rose(internal_reset_o) |-> ##2 reset_vector_o ==
      (monitor_mode_i ? srcs_pkg::VECTOR_MONITOR : srcs_pkg::VECTOR_USER))
      else $error("reset vector wrong");
   rd_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside read slot");
   cause_rsvd_a: assert property ($past(reg_read_i) &&
      $past(reg_addr_i) == srcs_pkg::RESET_CAUSE_FLAGS_OFF |->
      reg_rdata_o[2] == 1'b0 && reg_rdata_o[0] == 1'b0) else $error("reserved cause bits set");
   opc_drive_a: assert property (bad_opcode_i && !internal_reset_o |->
      ##[1:3] !reset_pin_oe_n_o) else $error("pin not driven on bad opcode");
   wdog_take_a: assert property (watchdog_req_i && !internal_reset_o |->
      ##[2:6] internal_reset_o) else $error("watchdog not taken");
   pin_halt_a: assert property (!reset_pin_i && reset_pin_oe_n_o && !internal_reset_o |->
      ##[1:4] internal_reset_o) else $error("pin low did not halt");
   cnt_clear_a: assert property (bad_opcode_i && !internal_reset_o |->
      ##[1:3] timing_count_o < 13'h0004) else $error("counter not cleared");
endmodule
bind srcs_sequencer srcs_sequencer_props #(.POR_TIMEOUT(POR_TIMEOUT)) i_srcs_sequencer_props (
   .sys_clk_i(sys_clk_i), .reset_i(reset_i), .monitor_mode_i(monitor_mode_i),
   .watchdog_req_i(watchdog_req_i), .bad_opcode_i(bad_opcode_i), .reset_pin_i(reset_pin_i),
   .reg_read_i(reg_read_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
   .reset_pin_o(reset_pin_o), .reset_pin_oe_n_o(reset_pin_oe_n_o),
   .internal_reset_o(internal_reset_o), .reset_vector_o(reset_vector_o),
   .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
   .timing_count_o(timing_count_o));

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the reset and clock sequencer.
// Assumes: Short power-on timeout of 64 cycles; pin thresholds stay full size.
// Notes: Reads queue their expected value; a monitor compares in the data cycle.
////////////////////////////////////////////////////////////////////////////////
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0, reset_i = 1'b1, core_src_en_i = 1'b0, monitor_mode_i = 1'b0;
   logic stop_req_i = 1'b0, wait_req_i = 1'b0, wake_i = 1'b0, break_wait_i = 1'b0;
   logic peer_low = 1'b0, reg_write_i = 1'b0, reg_read_i = 1'b0, rd_seen = 1'b0;
   logic [3:0] src = 4'h0;
   logic [23:0] irq_i = 24'h000000;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [7:0] exp_q[$], msk_q[$];
   logic [7:0] reg_rdata_o, cause_tab [4];
   logic reset_pin_i, reset_pin_o, reset_pin_oe_n_o, internal_reset_o;
   logic cpu_clk_en_o, periph_clk_en_o, wait_clk_en_o;
   logic [15:0] reset_vector_o;
   logic [23:0] irq_pending_o;
   logic [srcs_pkg::CNT_W-1:0] timing_count_o;
   int mismatches = 0, total_checks = 0;
   srcs_sequencer #(.POR_TIMEOUT(64)) i_srcs_sequencer (.sys_clk_i(sys_clk_i),
      .reset_i(reset_i), .core_src_en_i(core_src_en_i), .monitor_mode_i(monitor_mode_i),
      .brownout_i(src[0]), .watchdog_req_i(src[1]), .bad_opcode_i(src[2]),
      .bad_fetch_address_i(src[3]), .stop_req_i(stop_req_i), .wait_req_i(wait_req_i),
      .wake_i(wake_i), .break_wait_i(break_wait_i), .irq_i(irq_i), .reset_pin_i(reset_pin_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
      .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .reset_pin_o(reset_pin_o),
      .reset_pin_oe_n_o(reset_pin_oe_n_o), .internal_reset_o(internal_reset_o),
      .reset_vector_o(reset_vector_o), .cpu_clk_en_o(cpu_clk_en_o),
      .periph_clk_en_o(periph_clk_en_o), .wait_clk_en_o(wait_clk_en_o),
      .irq_pending_o(irq_pending_o), .timing_count_o(timing_count_o));
   srcs_pin_model i_srcs_pin_model (.reset_pin_o(reset_pin_o),
      .reset_pin_oe_n_o(reset_pin_oe_n_o), .peer_low_i(peer_low), .reset_pin_i(reset_pin_i));
   always #2 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) core_src_en_i <= ~core_src_en_i;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Strobes drop one cycle before the next request so no signal is assigned twice at an edge.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      cyc(1);
      reg_write_i <= 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      cyc(1);
      reg_read_i <= 1'b0;
      cyc(1);
   endtask
   task automatic wait_run(input int lim);
      int i;
      i = 0;
      while (internal_reset_o !== 1'b0 && i < lim) begin
         cyc(1);
         i++;
      end
      if (i >= lim) begin
         mismatches++;
         $display("Error internal_reset_o expected 0 seen 1");
         finish_test();
      end
   endtask
   task automatic wait_bus(output int n);
      n = 1;
      cyc(1);
      while (cpu_clk_en_o !== 1'b1 && n < 300) begin
         cyc(1);
         n++;
      end
      if (n >= 300) begin
         mismatches++;
         $display("Error cpu_clk_en_o expected 1 seen 0");
         finish_test();
      end
   endtask
   always @(posedge sys_clk_i) begin
      if (rd_seen) check("reg_rdata_o", {16'h0000, exp_q.pop_front()},
         {16'h0000, reg_rdata_o & msk_q.pop_front()});
      rd_seen <= reg_read_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int n;
      cause_tab = '{8'h02, 8'h20, 8'h10, 8'h08};
      void'($urandom(42));
      cyc(4);
      reset_i <= 1'b0;
      cyc(3);
      wait_run(400);
      rd(srcs_pkg::RESET_CAUSE_FLAGS_OFF, srcs_pkg::CAUSE_RESET, 8'hFF);
      wr(srcs_pkg::RESET_CAUSE_FLAGS_OFF, 8'hFF);
      rd(srcs_pkg::RESET_CAUSE_FLAGS_OFF, srcs_pkg::CAUSE_RESET, 8'hFF);
      rd(16'hFE05, 8'h00, 8'hFF);
      $display("power-on and register map done");
      wait_bus(n);
      wait_bus(n);
      check("bus period", 24'd4, n);
      irq_i <= 24'($urandom());
      cyc(3);
      check("irq_pending_o", irq_i, irq_pending_o);
      wait_req_i <= 1'b1;
      cyc(4);
      n = 0;
      repeat (16) begin
         cyc(1);
         n += (cpu_clk_en_o === 1'b1) ? 100 : 0;
         n += (periph_clk_en_o === 1'b1 || wait_clk_en_o === 1'b1) ? 1 : 0;
      end
      check("wait mode clocks", 24'd1, 24'(n > 0 && n < 100));
      wait_req_i <= 1'b0;
      wake_i <= 1'b1;
      cyc(1);
      wake_i <= 1'b0;
      break_wait_i <= 1'b1;
      cyc(1);
      break_wait_i <= 1'b0;
      rd(srcs_pkg::BREAK_STATE_FLAGS_OFF, 8'h02, 8'h02);
      wr(srcs_pkg::BREAK_FLAG_CLEAR_CONTROL_OFF, 8'h80);
      rd(srcs_pkg::BREAK_FLAG_CLEAR_CONTROL_OFF, 8'h80, 8'h80);
      wr(srcs_pkg::BREAK_STATE_FLAGS_OFF, 8'h00);
      rd(srcs_pkg::BREAK_STATE_FLAGS_OFF, 8'h00, 8'h02);
      $display("clocks and break flag done");
      for (int s = 0; s < 2; s++) begin
         wr(srcs_pkg::WAKE_CTRL_OFF, 8'(s));
         stop_req_i <= 1'b1;
         cyc(1);
         stop_req_i <= 1'b0;
         cyc(8);
         wake_i <= 1'b1;
         cyc(1);
         wake_i <= 1'b0;
         wait_bus(n);
         check("stop exit delay", 24'd1, 24'(n >= (s ? 31 : 63) && n <= (s ? 40 : 72)));
      end
      $display("stop recovery done");
      for (int k = 3; k >= 0; k--) begin
         monitor_mode_i <= k[0];
         src[k] <= 1'b1;
         cyc(2);
         src[k] <= 1'b0;
         cyc(5);
         check("reset_vector_o", k[0] ? srcs_pkg::VECTOR_MONITOR : srcs_pkg::VECTOR_USER,
            reset_vector_o);
         wait_run(400);
         rd(srcs_pkg::RESET_CAUSE_FLAGS_OFF, cause_tab[k], 8'hFF);
         peer_low <= (k != 0);
         cyc(k != 0 ? 80 : 100);
         peer_low <= 1'b0;
         cyc(3);
         wait_run(200);
         rd(srcs_pkg::RESET_CAUSE_FLAGS_OFF, k ? 8'h40 : 8'h02, 8'hFF);
      end
      monitor_mode_i <= 1'b0;
      peer_low <= 1'b1;
      cyc(100);
      peer_low <= 1'b0;
      cyc(3);
      wait_run(200);
      rd(srcs_pkg::RESET_CAUSE_FLAGS_OFF, 8'h40, 8'hFF);
      $display("reset sources done");
      cyc(2);
      finish_test();
   end
endmodule
